/* rtl/ppm_pkg.sv */
package ppm_pkg;
    // Reset values of the control bits this block holds
    localparam logic [7:0] P1_DIR_RST = 8'h00;
    localparam logic [7:0] P1_SEL_RST = 8'h00;
    localparam logic [7:0] P2_DIR_RST = 8'h00;
    localparam logic [7:0] P2_SEL_RST = 8'h40; // Crystal input selected on bit 6
    localparam logic [7:0] AE_RST = 8'h00;
    localparam logic EXT_R_RST = 1'b0;
    // Bit positions and the analog pin count
    localparam int P1_PIN = 7;
    localparam int XTAL_PIN = 6;
    localparam int ROSC_PIN = 5;
    localparam int ANALOG_PINS = 5;

    // Peripheral outputs toward the pins
    typedef struct packed {
        logic timer_compare_out_0;
        logic timer_compare_out_1;
        logic timer_compare_out_2;
        logic aux_clock;
        logic sub_main_clock;
    } ppm_periph_out_s;

    // Pin-derived signals toward peripherals
    typedef struct packed {
        logic timer_capture_in_0_alt;
        logic timer_capture_in_1_alt;
        logic timer_inverted_clock_in;
        logic crystal_input;
        logic [4:0] analog_connect;
        logic resistor_connect;
        logic crystal_connect;
        logic test_data_in;
    } ppm_periph_in_s;
endpackage : ppm_pkg

/* rtl/ppm_port_pin_mux.sv */
`timescale 1ns/100ps
// Contract
// [RULE1] P1.7 plain I/O when select and test off
// [RULE2] P1.7 direction and select set: compare 2
// [RULE3] Test mode gives P1.7 to test logic
// [RULE4] Pins reset into plain I/O, except P2.6
// [RULE5] P2.0 select and direction: auxiliary clock out
// [RULE6] P2.2 select: capture 0 in or compare 0
// [RULE7] P2.0-4 analog enable overrides direction and select
// [RULE8] Analog enable kills output driver and input
// [RULE9] P2.1 select: inverted clock in or sub-main clock
// [RULE10] P2.3 select: capture 1 or compare 1
// [RULE11] P2.4 select and direction: compare 2
// [RULE12] P2.5 resistor select wins; else ground drive
// [RULE13] P2.5 select, direction 0: no function
// [RULE14] P2.6 select picks crystal input over I/O
// [RULE15] P2.6 resets to crystal input
// [RULE16] Pin drive follows selected function
module ppm_port_pin_mux (
    input wire logic clk, // 20 MHz system clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [7:0] port1_direction_bit, // Port-1 direction bits
    input wire logic [7:0] port1_function_select, // Port-1 select bits
    input wire logic [7:0] port2_direction_bit, // Port-2 direction bits
    input wire logic [7:0] port2_function_select, // Port-2 select bits
    input wire logic [7:0] analog_input_enable, // Analog enable per channel
    input wire logic external_resistor_select, // Resistor on P2.5
    input wire logic [7:0] port1_out, // Port-1 output data
    input wire logic [7:0] port2_out, // Port-2 output data
    input wire logic test_mode, // 4-wire test mode active
    input wire logic test_data_out, // Test data from test logic
    input wire logic test_data_oe, // Test logic drives P1.7
    input wire ppm_pkg::ppm_periph_out_s periph_out, // Peripheral outputs
    input wire logic p1_7_in, // P1.7 pin level
    input wire logic [6:0] p2_in, // P2.0-6 pin levels
    output logic p1_7_out, // P1.7 pin drive value
    output logic p1_7_oe, // P1.7 pin drive enable
    output logic [6:0] p2_out, // P2.0-6 pin drive values
    output logic [6:0] p2_oe, // P2.0-6 pin drive enables
    output logic p1_7_gpio_in, // Port-1 bit 7 input value
    output logic [6:0] p2_gpio_in, // Port-2 input values
    output ppm_pkg::ppm_periph_in_s periph_in // Signals to peripherals
);
    // Control bits are captured so that the pin function has a defined reset state
    logic [7:0] p1_dir_q, p1_sel_q, p2_dir_q, p2_sel_q, ae_q;
    logic ext_r_q, test_q;
    logic p1_7_s1_q, p1_7_s2_q;
    logic [6:0] p2_s1_q, p2_s2_q;
    logic p1_7_out_d, p1_7_oe_d, p1_7_gin_d;
    logic [6:0] p2_out_d, p2_oe_d, p2_gin_d;
    ppm_pkg::ppm_periph_in_s periph_in_d;

    // Register the control bits; reset puts P2.6 on the crystal
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p1_dir_q <= ppm_pkg::P1_DIR_RST; // RULE4
            p1_sel_q <= ppm_pkg::P1_SEL_RST;
            p2_dir_q <= ppm_pkg::P2_DIR_RST;
            p2_sel_q <= ppm_pkg::P2_SEL_RST; // RULE15
            ae_q <= ppm_pkg::AE_RST;
            ext_r_q <= ppm_pkg::EXT_R_RST;
            test_q <= 1'b0;
        end else begin
            p1_dir_q <= port1_direction_bit;
            p1_sel_q <= port1_function_select;
            p2_dir_q <= port2_direction_bit;
            p2_sel_q <= port2_function_select;
            ae_q <= analog_input_enable;
            ext_r_q <= external_resistor_select;
            test_q <= test_mode;
        end
    end

    // Two-stage synchronisers on the pin levels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p1_7_s1_q <= 1'b0;
            p1_7_s2_q <= 1'b0;
            p2_s1_q <= 7'h00;
            p2_s2_q <= 7'h00;
        end else begin
            p1_7_s1_q <= p1_7_in;
            p1_7_s2_q <= p1_7_s1_q;
            p2_s1_q <= p2_in;
            p2_s2_q <= p2_s1_q;
        end
    end

    // Port-1 bit 7 function choice; test mode overrides everything
    always_comb begin
        p1_7_out_d = port1_out[ppm_pkg::P1_PIN]; // RULE1
        p1_7_oe_d = p1_dir_q[ppm_pkg::P1_PIN]; // RULE1
        p1_7_gin_d = p1_7_s2_q;
        if (test_q) begin
            p1_7_out_d = test_data_out; // RULE3
            p1_7_oe_d = test_data_oe; // RULE3
            p1_7_gin_d = 1'b0;
        end else if (p1_sel_q[ppm_pkg::P1_PIN]) begin
            // Select with direction 0 has no input function: stay undriven
            p1_7_out_d = periph_out.timer_compare_out_2; // RULE2
            p1_7_oe_d = p1_dir_q[ppm_pkg::P1_PIN]; // RULE2
        end
    end

    // Port-2 function choice per pin
    always_comb begin
        p2_out_d = port2_out[6:0];
        p2_oe_d = p2_dir_q[6:0] & ~p2_sel_q[6:0];
        p2_gin_d = p2_s2_q;
        periph_in_d = '0;
        // Selected peripheral outputs
        if (p2_sel_q[0]) p2_out_d[0] = periph_out.aux_clock; // RULE5
        if (p2_sel_q[0]) p2_oe_d[0] = p2_dir_q[0]; // RULE5
        if (p2_sel_q[1]) p2_out_d[1] = periph_out.sub_main_clock; // RULE9
        if (p2_sel_q[1]) p2_oe_d[1] = p2_dir_q[1]; // RULE9
        if (p2_sel_q[2]) p2_out_d[2] = periph_out.timer_compare_out_0; // RULE6
        if (p2_sel_q[2]) p2_oe_d[2] = p2_dir_q[2]; // RULE6
        if (p2_sel_q[3]) p2_out_d[3] = periph_out.timer_compare_out_1; // RULE10
        if (p2_sel_q[3]) p2_oe_d[3] = p2_dir_q[3]; // RULE10
        if (p2_sel_q[4]) p2_out_d[4] = periph_out.timer_compare_out_2; // RULE11
        if (p2_sel_q[4]) p2_oe_d[4] = p2_dir_q[4]; // RULE11
        // Ground drive on P2.5; direction 0 leaves it floating
        if (p2_sel_q[ppm_pkg::ROSC_PIN]) begin
            p2_out_d[ppm_pkg::ROSC_PIN] = 1'b0; // RULE12
            p2_oe_d[ppm_pkg::ROSC_PIN] = p2_dir_q[ppm_pkg::ROSC_PIN]; // RULE13
        end
        // Capture and clock inputs only when selected as inputs
        periph_in_d.timer_inverted_clock_in = p2_sel_q[1] & ~p2_dir_q[1] & p2_s2_q[1]; // RULE9
        periph_in_d.timer_capture_in_0_alt = p2_sel_q[2] & ~p2_dir_q[2] & p2_s2_q[2]; // RULE6
        periph_in_d.timer_capture_in_1_alt = p2_sel_q[3] & ~p2_dir_q[3] & p2_s2_q[3]; // RULE10
        // Crystal input ignores direction
        if (p2_sel_q[ppm_pkg::XTAL_PIN]) begin
            p2_oe_d[ppm_pkg::XTAL_PIN] = 1'b0; // RULE14
            periph_in_d.crystal_connect = 1'b1; // RULE14
            periph_in_d.crystal_input = p2_s2_q[ppm_pkg::XTAL_PIN]; // RULE14
        end
        // Resistor select wins over direction and select
        if (ext_r_q) begin
            p2_oe_d[ppm_pkg::ROSC_PIN] = 1'b0; // RULE12
            periph_in_d.resistor_connect = 1'b1; // RULE12
            p2_gin_d[ppm_pkg::ROSC_PIN] = 1'b0;
        end
        // Analog last so it overrides; driver and input buffer both blocked
        for (int i = 0; i < ppm_pkg::ANALOG_PINS; i++) begin
            if (ae_q[i]) begin
                p2_oe_d[i] = 1'b0; // RULE8
                p2_gin_d[i] = 1'b0; // RULE8
                periph_in_d.analog_connect[i] = 1'b1; // RULE7
            end
        end
        if (periph_in_d.analog_connect[2]) periph_in_d.timer_capture_in_0_alt = 1'b0;
        if (periph_in_d.analog_connect[3]) periph_in_d.timer_capture_in_1_alt = 1'b0;
        if (periph_in_d.analog_connect[1]) periph_in_d.timer_inverted_clock_in = 1'b0;
        periph_in_d.test_data_in = test_q & p1_7_s2_q;
    end

    // Outputs registered straight from flip-flops, one cycle after the controls
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p1_7_out <= 1'b0;
            p1_7_oe <= 1'b0;
            p2_out <= 7'h00;
            p2_oe <= 7'h00;
            p1_7_gpio_in <= 1'b0;
            p2_gpio_in <= 7'h00;
            periph_in <= '0;
        end else begin
            p1_7_out <= p1_7_out_d; // RULE16
            p1_7_oe <= p1_7_oe_d; // RULE16
            p2_out <= p2_out_d; // RULE16
            p2_oe <= p2_oe_d; // RULE16
            p1_7_gpio_in <= p1_7_gin_d;
            p2_gpio_in <= p2_gin_d;
            periph_in <= periph_in_d;
        end
    end

    // Named steps: the reset exit, and control patterns held in the flops that are answered on the next edge
    sequence s_reset_exit;
        !nrst ##1 nrst;
    endsequence : s_reset_exit
    sequence s_cmp0_in;
        !ae_q[2] && p2_sel_q[2] && !p2_dir_q[2];
    endsequence : s_cmp0_in
    sequence s_cmp1_in;
        !ae_q[3] && p2_sel_q[3] && !p2_dir_q[3];
    endsequence : s_cmp1_in
    sequence s_clk_in;
        !ae_q[1] && p2_sel_q[1] && !p2_dir_q[1];
    endsequence : s_clk_in
    sequence s_cmp0_out;
        !ae_q[2] && p2_sel_q[2] && p2_dir_q[2];
    endsequence : s_cmp0_out
    sequence s_cmp1_out;
        !ae_q[3] && p2_sel_q[3] && p2_dir_q[3];
    endsequence : s_cmp1_out
    sequence s_cmp2_out;
        !ae_q[4] && p2_sel_q[4] && p2_dir_q[4];
    endsequence : s_cmp2_out

    // Reset leaves the covered pins in plain I/O and P2.6 on the crystal
    a_reset_plain_io: assert property (@(posedge clk) // RULE4
        s_reset_exit |-> !p1_sel_q[7] && !test_q && p2_sel_q[5:0] == 6'h00)
        else $error("reset left a pin off plain I/O");
    a_reset_drive_off: assert property (@(posedge clk) // RULE4
        !nrst |=> !p1_7_oe && p2_oe == 7'h00) else $error("pin driven out of reset");
    a_reset_crystal: assert property (@(posedge clk) // RULE15
        s_reset_exit |-> p2_sel_q[6]) else $error("crystal not default after reset");

    // Analog enable must keep the driver off and the input buffer blocked next cycle
    a_analog_drv_off: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        ae_q[0] |=> !p2_oe[0]) else $error("analog pin 0 driven");
    a_analog_oe_all: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        1'b1 |=> (p2_oe[4:0] & $past(ae_q[4:0])) == 5'h00)
        else $error("analog pin driven");
    a_analog_in_block: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        1'b1 |=> (p2_gpio_in[4:0] & $past(ae_q[4:0])) == 5'h00)
        else $error("analog input buffer open");
    a_analog_link: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        ae_q[3] |=> periph_in.analog_connect[3] && !p2_gpio_in[3]) else $error("analog 3");
    a_analog_map: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        1'b1 |=> periph_in.analog_connect == $past(ae_q[4:0])) else $error("analog map");
    a_cap0_analog: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        ae_q[2] |=> !periph_in.timer_capture_in_0_alt) else $error("capture 0 not blocked");
    a_cap1_analog: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        ae_q[3] |=> !periph_in.timer_capture_in_1_alt) else $error("capture 1 not blocked");
    a_timer_inverted_clock_in_analog: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        ae_q[1] |=> !periph_in.timer_inverted_clock_in) else $error("clock in not blocked");

    // P1.7: test mode first, then the compare output, else plain I/O
    a_test_owns_p1: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        test_q |=> p1_7_oe == $past(test_data_oe)) else $error("test drive lost");
    a_test_drive_val: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        test_q |=> p1_7_out == $past(test_data_out)) else $error("test data lost");
    a_test_data_in: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        test_q |=> periph_in.test_data_in == $past(p1_7_s2_q) && !p1_7_gpio_in)
        else $error("test input wrong");
    a_test_data_idle: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        !test_q |=> !periph_in.test_data_in) else $error("test input leaks");
    a_p1_compare_out: assert property (@(posedge clk) disable iff (!nrst) // RULE2
        !test_q && p1_sel_q[7] && p1_dir_q[7] |=> p1_7_oe
            && p1_7_out == $past(periph_out.timer_compare_out_2)) else $error("P1.7 compare missing");
    a_p1_sel_no_dir: assert property (@(posedge clk) disable iff (!nrst) // RULE2
        !test_q && p1_sel_q[7] && !p1_dir_q[7] |=> !p1_7_oe) else $error("P1.7 driven");
    a_p1_gpio_dir: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        !test_q && !p1_sel_q[7] |=> p1_7_oe == $past(p1_dir_q[7])) else $error("P1.7 dir wrong");
    a_p1_gpio_data: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        !test_q && !p1_sel_q[7] |=> p1_7_out == $past(port1_out[7])) else $error("P1.7 data");
    a_p1_gpio_in: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        !test_q |=> p1_7_gpio_in == $past(p1_7_s2_q)) else $error("P1.7 input lost");

    // P2.0 to P2.4: peripheral outputs, capture inputs and plain I/O
    a_aux_clock: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        !ae_q[0] && p2_sel_q[0] && p2_dir_q[0] |=> p2_oe[0]
            && p2_out[0] == $past(periph_out.aux_clock)) else $error("aux clock missing");
    a_sub_main_clock_out: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        !ae_q[1] && p2_sel_q[1] && p2_dir_q[1] |=> p2_oe[1]
            && p2_out[1] == $past(periph_out.sub_main_clock)) else $error("sub-main clock missing");
    a_cmp0_out: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        !ae_q[2] && p2_sel_q[2] && p2_dir_q[2] |=> p2_oe[2]) else $error("compare 0 off");
    a_cmp0_value: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        s_cmp0_out |=> p2_out[2] == $past(periph_out.timer_compare_out_0))
        else $error("compare 0 value");
    a_cmp1_out: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        !ae_q[3] && p2_sel_q[3] && p2_dir_q[3] |=> p2_oe[3]) else $error("compare 1 off");
    a_cmp1_value: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        s_cmp1_out |=> p2_out[3] == $past(periph_out.timer_compare_out_1))
        else $error("compare 1 value");
    a_cmp2_out: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        !ae_q[4] && p2_sel_q[4] && p2_dir_q[4] |=> p2_oe[4]) else $error("compare 2 off");
    a_cmp2_value: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        s_cmp2_out |=> p2_out[4] == $past(periph_out.timer_compare_out_2))
        else $error("compare 2 value");
    a_cap0_route: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        s_cmp0_in |=> periph_in.timer_capture_in_0_alt == $past(p2_s2_q[2]) && !p2_oe[2])
        else $error("capture 0 route");
    a_cap1_route: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        s_cmp1_in |=> periph_in.timer_capture_in_1_alt == $past(p2_s2_q[3]) && !p2_oe[3])
        else $error("capture 1 route");
    a_timer_inverted_clock_in_route: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        s_clk_in |=> periph_in.timer_inverted_clock_in == $past(p2_s2_q[1]) && !p2_oe[1])
        else $error("clock input route");
    a_p2_gpio_dir: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        1'b1 |=> (p2_oe[4:0] & ~$past(ae_q[4:0] | p2_sel_q[4:0]))
            == ($past(p2_dir_q[4:0]) & ~$past(ae_q[4:0] | p2_sel_q[4:0])))
        else $error("P2 plain I/O direction");
    a_gpio_in_pass: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        1'b1 |=> (p2_gpio_in[4:0] | $past(ae_q[4:0]))
            == ($past(p2_s2_q[4:0]) | $past(ae_q[4:0]))) else $error("P2 input lost");

    // P2.5 resistor and ground drive, P2.6 crystal input
    a_rosc_no_drive: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        ext_r_q |=> !p2_oe[5] && periph_in.resistor_connect) else $error("P2.5 resistor");
    a_rosc_in_block: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        ext_r_q |=> !p2_gpio_in[5]) else $error("P2.5 input open");
    a_rosc_ground: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        !ext_r_q && p2_sel_q[5] && p2_dir_q[5] |=> p2_oe[5] && !p2_out[5]) else $error("no ground");
    a_rosc_none: assert property (@(posedge clk) disable iff (!nrst) // RULE13
        !ext_r_q && p2_sel_q[5] && !p2_dir_q[5] |=> !p2_oe[5]) else $error("P2.5 driven");
    a_xtal_input: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        p2_sel_q[6] |=> !p2_oe[6] && periph_in.crystal_connect) else $error("xtal drive");
    a_xtal_value: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        p2_sel_q[6] |=> periph_in.crystal_input == $past(p2_s2_q[6]))
        else $error("crystal level lost");
    a_p26_gpio: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        !p2_sel_q[6] |=> p2_oe[6] == $past(p2_dir_q[6]) && !periph_in.crystal_connect)
        else $error("P2.6 plain I/O");
endmodule : ppm_port_pin_mux

/* tb/ppm_pin_model.sv */
`timescale 1ns/100ps
// Package pins: a pin shows its own drive while enabled, else the board level
module ppm_pin_model (
    input wire logic p1_7_out, // P1.7 drive value
    input wire logic p1_7_oe, // P1.7 drive enable
    input wire logic [6:0] p2_out, // P2 drive values
    input wire logic [6:0] p2_oe, // P2 drive enables
    input wire logic board_p1, // Board level on P1.7 when released
    input wire logic [6:0] board_p2, // Board levels on P2 when released
    output logic p1_7_in, // Resolved P1.7 level
    output logic [6:0] p2_in // Resolved P2 levels
);
    // Per-bit resolution, so a released pin never echoes its last driven value
    assign p1_7_in = p1_7_oe ? p1_7_out : board_p1;
    assign p2_in = (p2_out & p2_oe) | (board_p2 & ~p2_oe);
endmodule : ppm_pin_model

/* tb/ppm_port_pin_mux_tb_top.sv */
`timescale 1ns/100ps
module ppm_port_pin_mux_tb_top;
    // Controls {p1 dir, p1 sel, test, resistor}, then expected pin view
    typedef struct packed {
        logic [3:0] ctl;
        logic [6:0] dir;
        logic [6:0] sel;
        logic [4:0] ae;
        logic [28:0] exp;
    } ppm_row_s;
    ppm_row_s rows [8] = '{
        {4'h0, 7'h00, 7'h00, 5'h00, 3'b001, 7'h00, 7'h00, 5'h00, 2'b00, 5'h13},
        {4'h8, 7'h7f, 7'h00, 5'h00, 3'b100, 7'h7f, 7'h2a, 5'h00, 2'b00, 5'h0a},
        {4'hc, 7'h1f, 7'h1f, 5'h00, 3'b111, 7'h1f, 7'h15, 5'h00, 2'b00, 5'h15},
        {4'he, 7'h00, 7'h0e, 5'h00, 3'b100, 7'h00, 7'h00, 5'h00, 2'b00, 5'h13},
        {4'h0, 7'h7f, 7'h1f, 5'h1f, 3'b001, 7'h60, 7'h20, 5'h1f, 2'b00, 5'h00},
        {4'h1, 7'h60, 7'h60, 5'h00, 3'b001, 7'h00, 7'h00, 5'h00, 2'b11, 5'h13},
        {4'h0, 7'h20, 7'h20, 5'h00, 3'b001, 7'h20, 7'h00, 5'h00, 2'b00, 5'h13},
        {4'h0, 7'h00, 7'h20, 5'h00, 3'b001, 7'h00, 7'h00, 5'h00, 2'b00, 5'h13}
    };
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] p1d = 8'h00, p1s = 8'h00, p2d = 8'h00, p2s = 8'h40, ae = 8'h00;
    logic extr = 1'b0, tmode = 1'b0, tdo = 1'b0, tdo_oe = 1'b1, ext_p1 = 1'b1;
    logic [6:0] ext_p2 = 7'h33;
    ppm_pkg::ppm_periph_out_s pout = 5'h16;
    logic p1_in, p1_out, p1_oe, p1_gin;
    logic [6:0] p2_in, p2_out, p2_oe, p2_gin;
    ppm_pkg::ppm_periph_in_s pin_s;
    int mismatches = 0;
    int checks_done = 0;

    // 50 ns period
    always #25 clk = ~clk;

    ppm_port_pin_mux dut (.clk(clk), .nrst(nrst), .port1_direction_bit(p1d),
        .port1_function_select(p1s), .port2_direction_bit(p2d), .port2_function_select(p2s),
        .analog_input_enable(ae), .external_resistor_select(extr), .port1_out(8'h00),
        .port2_out(8'h2a), .test_mode(tmode), .test_data_out(tdo), .test_data_oe(tdo_oe),
        .periph_out(pout), .p1_7_in(p1_in), .p2_in(p2_in), .p1_7_out(p1_out),
        .p1_7_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .p1_7_gpio_in(p1_gin),
        .p2_gpio_in(p2_gin), .periph_in(pin_s));

    ppm_pin_model pins (.p1_7_out(p1_out), .p1_7_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe),
        .board_p1(ext_p1), .board_p2(ext_p2), .p1_7_in(p1_in), .p2_in(p2_in));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Control flop, output flop, then two synchronisers and the input flop: five edges
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    task automatic final_report();
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // Main sequence: reset, table, then the awkward cases
    initial begin
        repeat (5) @(posedge clk);
        #1;
        check("oe_in_reset", {p1_oe, p2_oe}, 32'h0);
        @(posedge clk);
        nrst <= 1'b1;
        settle();
        check("reset_oe", {p1_oe, p2_oe}, 32'h0);
        check("reset_xtal", pin_s.crystal_connect, 32'h1);
        foreach (rows[i]) begin
            @(posedge clk);
            {p1d[7], p1s[7], tmode, extr} <= rows[i].ctl;
            p2d <= {1'b0, rows[i].dir};
            p2s <= {1'b0, rows[i].sel};
            ae <= {3'b000, rows[i].ae};
            settle();
            check($sformatf("row%0d", i), {3'b000, p1_oe, p1_out & p1_oe, p1_gin, p2_oe,
                p2_out & p2_oe, pin_s.analog_connect, pin_s.resistor_connect,
                pin_s.crystal_connect, p2_gin[4:0]}, {3'b000, rows[i].exp});
        end
        // Pin levels reach the capture, clock, crystal and test inputs
        @(posedge clk);
        p2s <= 8'h4e;
        tmode <= 1'b1;
        tdo_oe <= 1'b0;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            ext_p1 <= v[0];
            ext_p2 <= {7{v[0]}};
            settle();
            check("pin_inputs", {pin_s.timer_capture_in_0_alt, pin_s.timer_capture_in_1_alt,
                pin_s.timer_inverted_clock_in, pin_s.crystal_input, pin_s.test_data_in},
                {5{v[0]}});
            check("test_released", {p1_oe, p2_oe}, 32'h0);
        end
        // Compare outputs follow the timer without waiting for control changes
        @(posedge clk);
        tmode <= 1'b0;
        p1d <= 8'h80;
        p1s <= 8'h80;
        p2d <= 8'h10;
        p2s <= 8'h10;
        settle();
        @(posedge clk);
        pout.timer_compare_out_2 <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("compare_follow", {p1_oe, p1_out, p2_oe[4], p2_out[4]}, 32'ha);
        final_report();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (1000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule : ppm_port_pin_mux_tb_top
